// >>> tsq_top.v
`timescale 1ns/10ps
`include "tsq_defs.vh"

// Overview of operation
// [R1] trace decision independent of stop/jump/advance
// [R2] stop wins over jump
// [R3] jump wins over advance
// [R4] codes 0 match, 1 always, 2 never
// [R5] codes 3-8 add count-versus-delay compare
// [R6] separate don't-care pattern per command
// [R7] per-level delay, counts clocks or patterns
// [R8] sixteen levels with end-level setting
// [R9] jump goes to programmed target level
// [R10] advance goes to next level
// [R11] finishing level readable as status
// [R12] trace stores one sample per hit; stop stores nothing itself
// [R13] count samples on level against delay
// [R14] 512-word memory, cursors 0 to 512
// [R15] modes 0/1 internal or master external
// [R16] mode 2 own or master external
// [R17] modes 3/4 external master, mixed sections
// [R18] mode 5 internal or 10ns; here the 10 ns source samples on every 50 ns system clock
// [R19] programmable internal sample period
// [R20] sample clock edge rise/fall/unused
// [R21] enable qualifiers in latch/demux only
// [R22] four acquisition modes per group
// [R23] arm resets level, counter, memory fill
module tsq_top (
	input wire clk_sys,
	input wire rst,
	input wire [47:0] probe_pin,
	input wire master_clk_pin,
	input wire [2:0] sect_clk_pin,
	input wire [2:0] sect_enq_pin,
	input wire [2:0] clk_mode,
	input wire [1:0] master_edge,
	input wire [5:0] sect_edge,
	input wire [5:0] sect_enq,
	input wire [5:0] sect_src,
	input wire [5:0] sect_in_mode,
	input wire [10:0] int_period_val,
	input wire [1:0] int_period_unit,
	input wire arm,
	input wire [255:0] lvl_cond,
	input wire [3071:0] lvl_pat,
	input wire [3071:0] lvl_care,
	input wire [63:0] lvl_jump,
	input wire [63:0] lvl_end,
	input wire [255:0] lvl_delay,
	input wire [15:0] lvl_cnt_pat,
	input wire [9:0] curs_c,
	input wire [9:0] curs_r,
	output reg acq_run_q,
	output reg acq_done_q,
	output reg [3:0] level_q,
	output reg [8:0] wr_addr_q,
	output reg [9:0] fill_cnt_q,
	output reg [16:0] cnt_q,
	output reg [47:0] curs_c_data_q,
	output reg [47:0] curs_r_data_q
);

reg mck_m_q;
reg mck_s_q;
reg mck_p_q;
reg mext_evt;
reg master_evt;
reg [5:0] src_eff;
reg [47:0] hold_q;
reg [47:0] mem [0:511];
reg [47:0] word;
reg any_strb;
reg [3:0] hit;
reg [3:0] mt;
reg [16:0] cnt_nxt;
reg [16:0] dly;
reg [3:0] code;
integer k;
wire int_tick;
wire [2:0] strb;
wire [47:0] sect_word;

// section source allowed by the clock mode
function [1:0] eff_src;
	input [2:0] mode;
	input [1:0] req;
	begin
		case (mode)
		`TSQ_CM_INT: eff_src = `TSQ_SRC_INT; // [R15]
		`TSQ_CM_EXT_SGL: eff_src = `TSQ_SRC_MASTER; // [R15]
		`TSQ_CM_EXT_MUL: eff_src = (req == `TSQ_SRC_OWN) ? `TSQ_SRC_OWN : `TSQ_SRC_MASTER; // [R16]
		`TSQ_CM_MIX_SGL: eff_src = (req == `TSQ_SRC_OWN) ? `TSQ_SRC_MASTER : req; // [R17]
		`TSQ_CM_MIX_MUL: eff_src = req; // [R17]
		`TSQ_CM_INT_EXT: eff_src = (req == `TSQ_SRC_FAST) ? `TSQ_SRC_FAST : `TSQ_SRC_INT; // [R18]
		default: eff_src = `TSQ_SRC_INT;
		endcase
	end
endfunction

// one command's condition against pattern hit and count
function cond_hit;
	input [3:0] cc;
	input m;
	input [16:0] c;
	input [16:0] d;
	begin
		case (cc)
		`TSQ_CC_MATCH: cond_hit = m; // [R4]
		`TSQ_CC_ALWAYS: cond_hit = 1'b1;
		`TSQ_CC_NEVER: cond_hit = 1'b0;
		`TSQ_CC_GT: cond_hit = m && (c > d); // [R5]
		`TSQ_CC_LT: cond_hit = m && (c < d);
		`TSQ_CC_EQ: cond_hit = m && (c == d);
		`TSQ_CC_GE: cond_hit = m && (c >= d);
		`TSQ_CC_LE: cond_hit = m && (c <= d);
		`TSQ_CC_NE: cond_hit = m && (c != d);
		default: cond_hit = 1'b0;
		endcase
	end
endfunction

tsq_iper u_iper (
	.clk_sys(clk_sys),
	.rst(rst),
	.period_val(int_period_val),
	.period_unit(int_period_unit),
	.tick_q(int_tick)
);

genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : g_sect
		tsq_sect u_sect (
			.clk_sys(clk_sys),
			.rst(rst),
			.data_pin(probe_pin[g*16 +: 16]),
			.eclk_pin(sect_clk_pin[g]),
			.enq_pin(sect_enq_pin[g]),
			.eclk_code(sect_edge[g*2 +: 2]),
			.enq_code(sect_enq[g*2 +: 2]),
			.in_mode(sect_in_mode[g*2 +: 2]),
			.src_sel(src_eff[g*2 +: 2]),
			.master_evt(master_evt),
			.int_tick(int_tick),
			.strb_q(strb[g]),
			.word_q(sect_word[g*16 +: 16])
		);
	end
endgenerate

// master clock source and per-section routing
always @* begin
	mext_evt = 1'b0;
	if (master_edge == `TSQ_EDGE_RISE) begin // [R20]
		mext_evt = mck_s_q & ~mck_p_q;
	end else if (master_edge == `TSQ_EDGE_FALL) begin
		mext_evt = ~mck_s_q & mck_p_q;
	end
	if (clk_mode == `TSQ_CM_INT || clk_mode == `TSQ_CM_INT_EXT) begin
		master_evt = int_tick;
	end else begin
		master_evt = mext_evt; // [R17]
	end
	for (k = 0; k < 3; k = k + 1) begin
		src_eff[k*2 +: 2] = eff_src(clk_mode, sect_src[k*2 +: 2]);
	end
end

// sequencer decision for the current sample
always @* begin
	any_strb = |strb;
	for (k = 0; k < 3; k = k + 1) begin
		word[k*16 +: 16] = strb[k] ? sect_word[k*16 +: 16] : hold_q[k*16 +: 16];
	end
	for (k = 0; k < 4; k = k + 1) begin
		mt[k] = ((word ^ lvl_pat[(level_q*4+k)*48 +: 48]) & lvl_care[(level_q*4+k)*48 +: 48]) == 48'h0; // [R6]
	end
	// count includes this sample; pattern mode counts advance-pattern hits
	if (lvl_cnt_pat[level_q]) begin // [R7]
		cnt_nxt = (cnt_q == `TSQ_CNT_MAX) ? cnt_q : cnt_q + {16'h0000, mt[`TSQ_CMD_ADV]};
	end else begin
		cnt_nxt = (cnt_q == `TSQ_CNT_MAX) ? cnt_q : cnt_q + 17'h00001; // [R13]
	end
	dly = {1'b0, lvl_delay[level_q*16 +: 16]};
	for (k = 0; k < 4; k = k + 1) begin
		code = lvl_cond[level_q*16 + k*4 +: 4];
		hit[k] = cond_hit(code, mt[k], cnt_nxt, dly); // [R13]
	end
end

always @(posedge clk_sys) begin
	if (rst) begin
		mck_m_q <= 1'b0;
		mck_s_q <= 1'b0;
		mck_p_q <= 1'b0;
		hold_q <= 48'h000000000000;
	end else begin
		mck_m_q <= master_clk_pin;
		mck_s_q <= mck_m_q;
		mck_p_q <= mck_s_q;
		hold_q <= word;
	end
end

// trace store, evaluated apart from the level commands
always @(posedge clk_sys) begin
	if (acq_run_q && !arm && any_strb && hit[`TSQ_CMD_TRACE]) begin // [R1]
		mem[wr_addr_q] <= word; // [R14]
	end
end

always @(posedge clk_sys) begin
	if (rst) begin
		acq_run_q <= 1'b0;
		acq_done_q <= 1'b0;
		level_q <= 4'h0;
		cnt_q <= 17'h00000;
		wr_addr_q <= 9'h000;
		fill_cnt_q <= 10'h000;
	end else if (arm) begin
		acq_run_q <= 1'b1; // [R23]
		acq_done_q <= 1'b0;
		level_q <= 4'h0;
		cnt_q <= 17'h00000;
		wr_addr_q <= 9'h000;
		fill_cnt_q <= 10'h000;
	end else if (acq_run_q && any_strb) begin
		if (hit[`TSQ_CMD_TRACE]) begin // [R1]
			wr_addr_q <= wr_addr_q + 9'h001;
			if (fill_cnt_q != 10'h200) begin
				fill_cnt_q <= fill_cnt_q + 10'h001;
			end
		end
		if (hit[`TSQ_CMD_STOP]) begin // [R2] [R12]
			acq_run_q <= 1'b0;
			acq_done_q <= 1'b1; // [R11]
		end else if (hit[`TSQ_CMD_JUMP]) begin // [R3]
			level_q <= lvl_jump[level_q*4 +: 4]; // [R9]
			cnt_q <= 17'h00000;
		end else if (hit[`TSQ_CMD_ADV]) begin
			if (level_q == lvl_end[level_q*4 +: 4]) begin // [R8]
				acq_run_q <= 1'b0;
				acq_done_q <= 1'b1;
			end else begin
				level_q <= level_q + 4'h1; // [R10]
			end
			cnt_q <= 17'h00000;
		end else begin
			cnt_q <= cnt_nxt;
		end
	end
end

// cursor read ports; 512 shows the latest sample
always @(posedge clk_sys) begin
	if (rst) begin
		curs_c_data_q <= 48'h000000000000;
		curs_r_data_q <= 48'h000000000000;
	end else begin
		if (curs_c < 10'h200) begin // [R14]
			curs_c_data_q <= mem[curs_c[8:0]];
		end else if (curs_c == 10'h200) begin
			curs_c_data_q <= hold_q;
		end else begin
			curs_c_data_q <= 48'h000000000000;
		end
		if (curs_r < 10'h200) begin
			curs_r_data_q <= mem[curs_r[8:0]];
		end else if (curs_r == 10'h200) begin
			curs_r_data_q <= hold_q;
		end else begin
			curs_r_data_q <= 48'h000000000000;
		end
	end
end

endmodule // tsq_top

// >>> tsq_defs.vh
`ifndef TSQ_DEFS_VH
`define TSQ_DEFS_VH

// clock and timing
`define TSQ_CLK_NS 50
`define TSQ_FAST_NS 10
`define TSQ_FAST_CYC ((`TSQ_FAST_NS + `TSQ_CLK_NS - 1) / `TSQ_CLK_NS)
`define TSQ_US_CYC (1000 / `TSQ_CLK_NS)
`define TSQ_MS_CYC (1000000 / `TSQ_CLK_NS)

// sizes
`define TSQ_SEC_W 16
`define TSQ_WORD_W 48
`define TSQ_LVL_N 16
`define TSQ_MEM_N 512
`define TSQ_CNT_MAX 17'h1ffff

// command slots within a level
`define TSQ_CMD_STOP 0
`define TSQ_CMD_JUMP 1
`define TSQ_CMD_ADV 2
`define TSQ_CMD_TRACE 3

// condition codes
`define TSQ_CC_MATCH 4'h0
`define TSQ_CC_ALWAYS 4'h1
`define TSQ_CC_NEVER 4'h2
`define TSQ_CC_GT 4'h3
`define TSQ_CC_LT 4'h4
`define TSQ_CC_EQ 4'h5
`define TSQ_CC_GE 4'h6
`define TSQ_CC_LE 4'h7
`define TSQ_CC_NE 4'h8

// clock modes
`define TSQ_CM_INT 3'h0
`define TSQ_CM_EXT_SGL 3'h1
`define TSQ_CM_EXT_MUL 3'h2
`define TSQ_CM_MIX_SGL 3'h3
`define TSQ_CM_MIX_MUL 3'h4
`define TSQ_CM_INT_EXT 3'h5

// section clock sources
`define TSQ_SRC_MASTER 2'h0
`define TSQ_SRC_INT 2'h1
`define TSQ_SRC_FAST 2'h2
`define TSQ_SRC_OWN 2'h3

// sample clock edge codes
`define TSQ_EDGE_RISE 2'h0
`define TSQ_EDGE_FALL 2'h1
`define TSQ_EDGE_NONE 2'h2

// enable qualifier codes
`define TSQ_ENQ_POS 2'h0
`define TSQ_ENQ_NEG 2'h1
`define TSQ_ENQ_NONE 2'h2

// acquisition modes
`define TSQ_IM_SAMPLE 2'h0
`define TSQ_IM_GLITCH 2'h1
`define TSQ_IM_LATCH 2'h2
`define TSQ_IM_DEMUX 2'h3

// internal period units
`define TSQ_UNIT_NS 2'h0
`define TSQ_UNIT_US 2'h1
`define TSQ_UNIT_MS 2'h2

`endif

// >>> tsq_iper.v
`timescale 1ns/10ps
`include "tsq_defs.vh"

module tsq_iper (
	input wire clk_sys,
	input wire rst,
	input wire [10:0] period_val,
	input wire [1:0] period_unit,
	output reg tick_q
);

reg [21:0] cnt_q;
wire [21:0] val_ext = {11'h000, period_val};

// period in system clocks, never below one
function [21:0] per_cyc;
	input [21:0] v;
	input [1:0] u;
	reg [21:0] r;
	begin
		r = 22'h000001;
		if (u == `TSQ_UNIT_NS) begin
			r = (v + 22'd49) / 22'd50;
		end else if (u == `TSQ_UNIT_US) begin
			r = v * 22'd20;
		end else if (u == `TSQ_UNIT_MS) begin
			r = v * 22'd20000;
		end
		if (r == 22'h000000) begin
			r = 22'h000001;
		end
		per_cyc = r;
	end
endfunction

wire [21:0] limit = per_cyc(val_ext, period_unit);

always @(posedge clk_sys) begin
	if (rst) begin
		cnt_q <= 22'h000000;
		tick_q <= 1'b0;
	end else if (cnt_q + 22'h000001 >= limit) begin // [R19]
		cnt_q <= 22'h000000;
		tick_q <= 1'b1;
	end else begin
		cnt_q <= cnt_q + 22'h000001;
		tick_q <= 1'b0;
	end
end

endmodule // tsq_iper

// >>> tsq_sect.v
`timescale 1ns/10ps
`include "tsq_defs.vh"

module tsq_sect (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] data_pin,
	input wire eclk_pin,
	input wire enq_pin,
	input wire [1:0] eclk_code,
	input wire [1:0] enq_code,
	input wire [1:0] in_mode,
	input wire [1:0] src_sel,
	input wire master_evt,
	input wire int_tick,
	output reg strb_q,
	output reg [15:0] word_q
);

reg [15:0] d_m_q;
reg [15:0] d_s_q;
reg [15:0] d_p_q;
reg [15:0] glitch_q;
reg [15:0] latch_q;
reg ck_m_q;
reg ck_s_q;
reg ck_p_q;
reg en_m_q;
reg en_s_q;
reg own_evt;
reg evt;
reg en_on;
reg [15:0] word_d;

always @* begin
	own_evt = 1'b0;
	if (eclk_code == `TSQ_EDGE_RISE) begin // [R20]
		own_evt = ck_s_q & ~ck_p_q;
	end else if (eclk_code == `TSQ_EDGE_FALL) begin
		own_evt = ~ck_s_q & ck_p_q;
	end
	// fast source: 10 ns rounds up to one system clock
	if (src_sel == `TSQ_SRC_MASTER) begin
		evt = master_evt;
	end else if (src_sel == `TSQ_SRC_INT) begin
		evt = int_tick;
	end else if (src_sel == `TSQ_SRC_FAST) begin
		evt = (`TSQ_FAST_CYC == 1);
	end else begin
		evt = own_evt;
	end
	en_on = 1'b1;
	if (enq_code == `TSQ_ENQ_POS) begin // [R21]
		en_on = en_s_q;
	end else if (enq_code == `TSQ_ENQ_NEG) begin
		en_on = ~en_s_q;
	end
	case (in_mode) // [R22]
	`TSQ_IM_GLITCH: word_d = d_s_q | glitch_q | (d_s_q ^ d_p_q);
	`TSQ_IM_LATCH: word_d = latch_q;
	`TSQ_IM_DEMUX: word_d = {latch_q[15:8], d_s_q[7:0]};
	default: word_d = d_s_q;
	endcase
end

always @(posedge clk_sys) begin
	if (rst) begin
		d_m_q <= 16'h0000;
		d_s_q <= 16'h0000;
		d_p_q <= 16'h0000;
		ck_m_q <= 1'b0;
		ck_s_q <= 1'b0;
		ck_p_q <= 1'b0;
		en_m_q <= 1'b0;
		en_s_q <= 1'b0;
		glitch_q <= 16'h0000;
		latch_q <= 16'h0000;
		strb_q <= 1'b0;
		word_q <= 16'h0000;
	end else begin
		d_m_q <= data_pin;
		d_s_q <= d_m_q;
		d_p_q <= d_s_q;
		ck_m_q <= eclk_pin;
		ck_s_q <= ck_m_q;
		ck_p_q <= ck_s_q;
		en_m_q <= enq_pin;
		en_s_q <= en_m_q;
		// qualifier only matters in latch and demux modes
		if (en_on && (in_mode == `TSQ_IM_LATCH || in_mode == `TSQ_IM_DEMUX)) begin // [R21]
			latch_q <= d_s_q;
		end
		if (evt) begin
			glitch_q <= 16'h0000;
		end else begin
			glitch_q <= glitch_q | (d_s_q ^ d_p_q);
		end
		strb_q <= evt;
		if (evt) begin
			word_q <= word_d;
		end
	end
end

endmodule // tsq_sect

// >>> tsq_top_props.sv
`timescale 1ns/10ps
module tsq_top_props (
	input wire clk_sys,
	input wire rst,
	input wire arm,
	input wire acq_run_q,
	input wire acq_done_q,
	input wire [3:0] level_q,
	input wire [8:0] wr_addr_q,
	input wire [9:0] fill_cnt_q,
	input wire [16:0] cnt_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_ARM_RUN: assert property (arm |=> acq_run_q && !acq_done_q) else $error("arm no run");
	AST_ARM_LVL: assert property (arm |=> level_q == 4'h0 && cnt_q == 17'h0) else $error("arm no clear");
	AST_ARM_MEM: assert property (arm |=> wr_addr_q == 9'h0 && fill_cnt_q == 10'h0) else $error("arm fill");
	AST_DONE_HOLD: assert property (acq_done_q && !arm |=> acq_done_q && $stable(level_q)) else $error("done moved");
	AST_RUN_EXCL: assert property (!(acq_run_q && acq_done_q)) else $error("run and done");
	AST_FILL_MAX: assert property (fill_cnt_q <= 10'h200) else $error("fill over");
	AST_FILL_STEP: assert property (!arm |=> fill_cnt_q - $past(fill_cnt_q) <= 10'h1) else $error("fill jump");
	AST_WR_STEP: assert property (!arm ##1 fill_cnt_q != $past(fill_cnt_q) |-> wr_addr_q == $past(wr_addr_q) + 9'h1)
		else $error("wr step");
	AST_IDLE_HOLD: assert property (!acq_run_q && !arm |=> $stable(fill_cnt_q) && $stable(wr_addr_q))
		else $error("idle store");
endmodule // tsq_top_props

bind tsq_top tsq_top_props u_props (.clk_sys(clk_sys), .rst(rst), .arm(arm), .acq_run_q(acq_run_q),
	.acq_done_q(acq_done_q), .level_q(level_q), .wr_addr_q(wr_addr_q), .fill_cnt_q(fill_cnt_q), .cnt_q(cnt_q));

// >>> tsq_probe_model.sv
`timescale 1ns/10ps
module tsq_probe_model (
	output reg master_clk_pin,
	output reg [47:0] probe_pin
);
	initial begin
		master_clk_pin = 1'b0;
		probe_pin = 48'h0;
	end
	task put(input [47:0] w);
		begin
			probe_pin = w;
			#200 master_clk_pin = 1'b1;
			#200 master_clk_pin = 1'b0;
			// hold over: after the clock falls, drive the inverted word
			probe_pin = ~w;
		end
	endtask
endmodule // tsq_probe_model

// >>> test_tsq_top.sv
`timescale 1ns/10ps
`include "tsq_defs.vh"
module test_tsq_top;
	localparam [35:0] TBL = 36'h113314011;
	reg clk_sys, rst, arm;
	reg [2:0] sect_clk_pin, sect_enq_pin, clk_mode;
	reg [1:0] master_edge, int_period_unit;
	reg [5:0] sect_edge, sect_enq, sect_src, sect_in_mode;
	reg [10:0] int_period_val;
	reg [255:0] lvl_cond, lvl_delay;
	reg [3071:0] lvl_pat, lvl_care;
	reg [63:0] lvl_jump, lvl_end;
	reg [15:0] lvl_cnt_pat;
	reg [9:0] curs_c, curs_r;
	wire master_clk_pin, acq_run_q, acq_done_q;
	wire [47:0] probe_pin, curs_c_data_q, curs_r_data_q;
	wire [3:0] level_q;
	wire [8:0] wr_addr_q;
	wire [9:0] fill_cnt_q;
	wire [16:0] cnt_q;
	integer miscompares, n_checks, c, i, k;

	tsq_top DUT (.clk_sys(clk_sys), .rst(rst), .probe_pin(probe_pin), .master_clk_pin(master_clk_pin),
		.sect_clk_pin(sect_clk_pin), .sect_enq_pin(sect_enq_pin), .clk_mode(clk_mode), .master_edge(master_edge),
		.sect_edge(sect_edge), .sect_enq(sect_enq), .sect_src(sect_src), .sect_in_mode(sect_in_mode),
		.int_period_val(int_period_val), .int_period_unit(int_period_unit), .arm(arm), .lvl_cond(lvl_cond),
		.lvl_pat(lvl_pat), .lvl_care(lvl_care), .lvl_jump(lvl_jump), .lvl_end(lvl_end), .lvl_delay(lvl_delay),
		.lvl_cnt_pat(lvl_cnt_pat), .curs_c(curs_c), .curs_r(curs_r), .acq_run_q(acq_run_q),
		.acq_done_q(acq_done_q), .level_q(level_q), .wr_addr_q(wr_addr_q), .fill_cnt_q(fill_cnt_q),
		.cnt_q(cnt_q), .curs_c_data_q(curs_c_data_q), .curs_r_data_q(curs_r_data_q));
	tsq_probe_model u_prb (.master_clk_pin(master_clk_pin), .probe_pin(probe_pin));

	task chk(input [47:0] got, input [47:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("FAIL %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task send(input [47:0] w);
		begin
			u_prb.put(w);
			repeat (4) @(posedge clk_sys);
			#1;
		end
	endtask
	task clr;
		begin
			@(posedge clk_sys);
			lvl_cond <= {64{`TSQ_CC_NEVER}};
			lvl_care <= 3072'h0;
			clk_mode <= `TSQ_CM_EXT_SGL;
		end
	endtask
	// cc is {trace, advance, jump, stop}
	task lvl(input integer l, input [15:0] cc, input [3:0] jt, input [15:0] d);
		begin
			lvl_cond[l*16+:16] <= cc;
			lvl_jump[l*4+:4] <= jt;
			lvl_delay[l*16+:16] <= d;
		end
	endtask
	task pat(input integer l, input integer k, input [47:0] w, input [47:0] m);
		begin
			lvl_pat[(l*4+k)*48+:48] <= w;
			lvl_care[(l*4+k)*48+:48] <= m;
		end
	endtask
	task go;
		begin
			@(posedge clk_sys);
			arm <= 1'b1;
			@(posedge clk_sys);
			arm <= 1'b0;
			#1;
			chk(acq_run_q, 1'h1);
			chk({level_q, wr_addr_q, fill_cnt_q}, 23'h0);
		end
	endtask
	task t_prio;
		begin
			clr;
			lvl(0, 16'h2000, 4'h5, 16'h0);
			pat(0, 0, 48'h0a, 48'hff);
			pat(0, 1, 48'h0a, 48'h0e);
			pat(0, 2, 48'h08, 48'h08);
			go;
			send(48'h0b);
			chk(level_q, 4'h5);
			chk(fill_cnt_q, 10'h0);
			go;
			send(48'h0a);
			chk({acq_done_q, level_q}, 5'h10);
			go;
			send(48'h0c);
			chk({acq_run_q, level_q}, 5'h11);
		end
	endtask
	task t_one;
		begin
			clr;
			lvl(0, 16'h1221, 4'h0, 16'h0);
			go;
			send(48'h123456789abc);
			chk({acq_done_q, level_q, fill_cnt_q}, 15'h4001);
			send(48'h0f0f0f0f0f0f);
			chk(fill_cnt_q, 10'h1);
			@(posedge clk_sys);
			curs_c <= 10'h0;
			curs_r <= 10'h201;
			repeat (2) @(posedge clk_sys);
			#1;
			chk(curs_c_data_q, 48'h123456789abc);
			chk(curs_r_data_q, 48'h0);
		end
	endtask
	task t_codes;
		begin
			for (c = 0; c < 9; c = c + 1) begin
				clr;
				lvl(0, {12'h122, c[3:0]}, 4'h0, 16'h3);
				pat(0, 0, 48'h55, 48'hff);
				go;
				k = 0;
				for (i = 1; i < 7; i = i + 1)
					if (k == 0) begin
						send(48'h55);
						if (acq_done_q === 1'b1)
							k = i;
					end
				chk(k, TBL[c*4+:4]);
			end
		end
	endtask
	task t_count;
		begin
			clr;
			lvl(0, 16'h1322, 4'h0, 16'h4);
			go;
			for (i = 0; i < 4; i = i + 1)
				send(48'h1 << i);
			chk({level_q, cnt_q}, 21'h4);
			send(48'h10);
			chk({level_q, fill_cnt_q, wr_addr_q}, 23'h80a05);
		end
	endtask
	task t_int;
		begin
			clr;
			clk_mode <= `TSQ_CM_INT;
			lvl(0, 16'h1222, 4'h0, 16'h0);
			go;
			repeat (100) @(posedge clk_sys);
			#1;
			chk(fill_cnt_q >= 10'h8 && fill_cnt_q <= 10'hb, 1'h1);
		end
	endtask
	// pattern-occurrence counting, then end level stops on advance
	task t_pcnt;
		begin
			clr;
			lvl_cnt_pat <= 16'h0001;
			lvl(0, 16'h2622, 4'h0, 16'h2);
			pat(0, 2, 48'h01, 48'hff);
			go;
			send(48'h01);
			send(48'h02);
			chk({level_q, cnt_q}, 21'h1);
			send(48'h01);
			chk(level_q, 4'h1);
			@(posedge clk_sys);
			lvl_cnt_pat <= 16'h0000;
			lvl_end[3:0] <= 4'h0;
			lvl(0, 16'h2122, 4'h0, 16'h0);
			go;
			send(48'h00);
			chk({acq_done_q, level_q}, 5'h10);
			@(posedge clk_sys);
			lvl_end[3:0] <= 4'hf;
		end
	endtask
	// own falling-edge section clocks; section a latched with positive qualifier held low
	task t_own;
		begin
			clr;
			clk_mode <= `TSQ_CM_EXT_MUL;
			master_edge <= `TSQ_EDGE_NONE;
			sect_src <= 6'h3f;
			sect_edge <= 6'h15;
			sect_enq <= 6'h28;
			sect_in_mode <= 6'h02;
			sect_clk_pin <= 3'h7;
			lvl(0, 16'h1221, 4'h0, 16'h0);
			go;
			fork
				u_prb.put(48'h123456789abc);
				begin
					repeat (6) @(posedge clk_sys);
					sect_clk_pin <= 3'h0;
				end
			join
			repeat (4) @(posedge clk_sys);
			#1;
			chk({acq_done_q, fill_cnt_q}, 11'h401);
			@(posedge clk_sys);
			curs_c <= 10'h0;
			repeat (2) @(posedge clk_sys);
			#1;
			chk(curs_c_data_q, 48'h123456780000);
			@(posedge clk_sys);
			master_edge <= `TSQ_EDGE_RISE;
			sect_src <= 6'h00;
			sect_edge <= 6'h00;
			sect_enq <= 6'h2a;
			sect_in_mode <= 6'h00;
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		miscompares = 0;
		n_checks = 0;
		{rst, arm, sect_clk_pin, sect_enq_pin, master_edge, sect_edge, sect_src, sect_in_mode} = 28'h8000000;
		{clk_mode, sect_enq, int_period_val, int_period_unit} = {`TSQ_CM_EXT_SGL, 6'h2a, 11'h1f4, `TSQ_UNIT_NS};
		{lvl_cond, lvl_pat, lvl_care, lvl_delay} = {{64{`TSQ_CC_NEVER}}, 6400'h0};
		{lvl_jump, lvl_end, lvl_cnt_pat, curs_c, curs_r} = {64'h0, {16{4'hf}}, 36'h0};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_prio;
		t_one;
		t_codes;
		t_count;
		t_int;
		t_pcnt;
		t_own;
		test_done;
	end
endmodule // test_tsq_top
